/* ftr_defs.svh */
// Offsets, field positions, reset values and timing figures of the readout block
`ifndef FTR_DEFS_SVH
`define FTR_DEFS_SVH

`define FTR_ADDR_FAN_DIV 8'h05
`define FTR_ADDR_TEMP_CFG 8'h06
`define FTR_ADDR_VOLT_BASE 8'h20
`define FTR_ADDR_TEMP_HIGH 8'h28
`define FTR_ADDR_FAN_FIRST 8'h29
`define FTR_ADDR_FAN_SECOND 8'h2A
`define FTR_ADDR_HOT 8'h2B
`define FTR_ADDR_HOT_HYST 8'h2C
`define FTR_ADDR_OVERTEMP 8'h2D
`define FTR_ADDR_OVERTEMP_HYST 8'h2E

`define FTR_FAN_DIV_RESET 8'h14
`define FTR_TEMP_CFG_RESET 8'h01
`define FTR_FAN_LEVEL_FIRST_BIT 0
`define FTR_FAN_LEVEL_SECOND_BIT 1
`define FTR_FAN_DIV_FIRST_LSB 2
`define FTR_FAN_DIV_SECOND_LSB 4
`define FTR_OS_ONE_TIME_BIT 2
`define FTR_HIRES_BIT 3
`define FTR_TEMP_LOW_LSB 4

`define FTR_CLK_HZ 100000000
`define FTR_REF_HZ 22500
`define FTR_SLOT_MS 100
`define FTR_HIRES_EXTRA_MS 1000
`define FTR_FAN_MAX 8'hFF
`define FTR_TACH_GATE_EDGES 2'h2
`define FTR_NUM_SLOTS 4'hA

`endif

/* ftr_pkg.sv */
// Types shared by the fan, voltage and temperature readout block
`default_nettype none
package ftr_pkg;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ftr_reg_req_t;

   typedef struct packed {
      logic done;
      logic [11:0] code;
   } ftr_conv_rsp_t;

   typedef enum logic [1:0] {
      FTR_DIV_1 = 2'b00,
      FTR_DIV_2 = 2'b01,
      FTR_DIV_4 = 2'b10,
      FTR_DIV_8 = 2'b11
   } ftr_fan_div_t;

   typedef enum logic [1:0] {
      FTR_F_IDLE = 2'b00,
      FTR_F_ARM = 2'b01,
      FTR_F_COUNT = 2'b10,
      FTR_F_DONE = 2'b11
   } ftr_fan_state_t;
endpackage : ftr_pkg
`default_nettype wire

/* ftr_readout.sv */
// Measurement result logic: voltage codes, fan tach counts, temperature words and setpoints
`default_nettype none
`include "ftr_defs.svh"

module ftr_readout #(
   parameter int unsigned REF_DIV = `FTR_CLK_HZ / `FTR_REF_HZ,
   parameter int unsigned SLOT_CYCLES = (`FTR_CLK_HZ / 1000) * `FTR_SLOT_MS,
   parameter int unsigned HIRES_EXTRA_CYCLES = (`FTR_CLK_HZ / 1000) * `FTR_HIRES_EXTRA_MS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic loop_enable,
   input wire ftr_pkg::ftr_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   output logic conv_start,
   output logic [2:0] conv_sel,
   output logic conv_hires,
   input wire ftr_pkg::ftr_conv_rsp_t conv_rsp,
   input wire logic first_tach_input,
   input wire logic second_tach_input,
   output logic hot_alarm,
   output logic overtemp_alarm,
   output logic overtemp_shutdown_output_n
);

   // Register storage
   logic [7:0] volt [0:6];
   logic [7:0] fan_count [0:1];
   logic [7:0] temp_high;
   logic [3:0] temp_low;
   logic [7:0] fan_div_reg;
   logic [3:0] temp_cfg;
   logic [7:0] hot_set;
   logic [7:0] hot_hyst;
   logic [7:0] os_set;
   logic [7:0] os_hyst;

   // Decode of the register port
   wire wr_fan_div = reg_req.wr && (reg_req.addr == `FTR_ADDR_FAN_DIV);
   wire wr_temp_cfg = reg_req.wr && (reg_req.addr == `FTR_ADDR_TEMP_CFG);
   wire wr_hot = reg_req.wr && (reg_req.addr == `FTR_ADDR_HOT);
   wire wr_hot_hyst = reg_req.wr && (reg_req.addr == `FTR_ADDR_HOT_HYST);
   wire wr_os = reg_req.wr && (reg_req.addr == `FTR_ADDR_OVERTEMP);
   wire wr_os_hyst = reg_req.wr && (reg_req.addr == `FTR_ADDR_OVERTEMP_HYST);
   wire hires = temp_cfg[`FTR_HIRES_BIT];
   wire [7:0] volt_index = reg_req.addr - `FTR_ADDR_VOLT_BASE;
   wire volt_hit = (reg_req.addr >= `FTR_ADDR_VOLT_BASE) && (volt_index < 8'h07);
   wire [3:0] temp_low_rd = {temp_low[3], hires ? temp_low[2:0] : 3'h0};

   // Read multiplexer; unmapped locations read as zero
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = 8'h00;
      if (volt_hit) begin
         next_rdata = volt[volt_index[2:0]];
      end else begin
         unique case (reg_req.addr)
            `FTR_ADDR_FAN_DIV: next_rdata = fan_div_reg;
            `FTR_ADDR_TEMP_CFG: next_rdata = {temp_low_rd, temp_cfg};
            `FTR_ADDR_TEMP_HIGH: next_rdata = temp_high;
            `FTR_ADDR_FAN_FIRST: next_rdata = fan_count[0];
            `FTR_ADDR_FAN_SECOND: next_rdata = fan_count[1];
            `FTR_ADDR_HOT: next_rdata = hot_set;
            `FTR_ADDR_HOT_HYST: next_rdata = hot_hyst;
            `FTR_ADDR_OVERTEMP: next_rdata = os_set;
            `FTR_ADDR_OVERTEMP_HYST: next_rdata = os_hyst;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_req.rd) begin
         reg_rdata <= next_rdata;
      end
   end

   // Software-written control registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fan_div_reg <= `FTR_FAN_DIV_RESET;
         temp_cfg <= 4'(`FTR_TEMP_CFG_RESET);
      end else begin
         if (wr_fan_div) fan_div_reg <= reg_req.wdata;
         if (wr_temp_cfg) temp_cfg <= reg_req.wdata[3:0];
      end
   end

   // Setpoints, one degree per step, two's complement
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hot_set <= 8'h00;
         hot_hyst <= 8'h00;
         os_set <= 8'h00;
         os_hyst <= 8'h00;
      end else begin
         if (wr_hot) hot_set <= reg_req.wdata;
         if (wr_hot_hyst) hot_hyst <= reg_req.wdata;
         if (wr_os) os_set <= reg_req.wdata;
         if (wr_os_hyst) os_hyst <= reg_req.wdata;
      end
   end

   // Round-robin sequencer: slot 0 temperature, 1..7 voltages, 8..9 fans
   logic [3:0] slot;
   logic [31:0] slot_timer;
   logic slot_got;
   wire [31:0] slot_len = (slot == 4'h0 && hires) ?
      32'(SLOT_CYCLES + HIRES_EXTRA_CYCLES) : 32'(SLOT_CYCLES);
   wire slot_end = loop_enable && (slot_timer == slot_len - 32'h1);
   wire slot_begin = loop_enable && (slot_timer == 32'h0);
   wire is_fan_slot = (slot >= 4'h8);
   wire fan_sel = slot[0];
   wire [3:0] next_slot = (slot == `FTR_NUM_SLOTS - 4'h1) ? 4'h0 : slot + 4'h1;
   wire conv_take = conv_rsp.done && !slot_got && !is_fan_slot && loop_enable;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slot <= 4'h0;
         slot_timer <= 32'h0;
         slot_got <= 1'b0;
      end else if (!loop_enable) begin
         slot <= 4'h0;
         slot_timer <= 32'h0;
         slot_got <= 1'b0;
      end else if (slot_end) begin
         slot <= next_slot;
         slot_timer <= 32'h0;
         slot_got <= 1'b0;
      end else begin
         slot_timer <= slot_timer + 32'h1;
         if (conv_take) slot_got <= 1'b1;
      end
   end

   assign conv_start = slot_begin && !is_fan_slot;
   assign conv_sel = slot[2:0];
   assign conv_hires = hires;

   // Temperature formatting
   logic [8:0] temp9;
   logic [11:0] temp12;
   assign temp9 = conv_rsp.code[11:3];
   assign temp12 = conv_rsp.code;
   wire temp_take = conv_take && (slot == 4'h0);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         temp_high <= 8'h00;
         temp_low <= 4'h0;
      end else if (temp_take) begin
         if (hires) begin
            temp_high <= temp12[11:4];
            temp_low <= temp12[3:0];
         end else begin
            temp_high <= temp9[8:1];
            temp_low <= {temp9[0], 3'b000};
         end
      end
   end

   // Voltage channels store the 8-bit code unchanged
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 7; i++) begin
            volt[i] <= 8'h00;
         end
      end else if (conv_take && slot != 4'h0) begin
         volt[slot[2:0] - 3'h1] <= conv_rsp.code[7:0];
      end
   end

   // Setpoint comparator on the signed top eight bits
   logic temp_updated;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         temp_updated <= 1'b0;
      end else begin
         temp_updated <= temp_take;
      end
   end

   wire signed [7:0] temp_s = temp_high;
   wire above_hot = temp_s > $signed(hot_set);
   wire below_hot_hyst = temp_s < $signed(hot_hyst);
   wire above_os = temp_s > $signed(os_set);
   wire below_os_hyst = temp_s < $signed(os_hyst);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hot_alarm <= 1'b0;
         overtemp_alarm <= 1'b0;
      end else if (temp_updated) begin
         if (above_hot) hot_alarm <= 1'b1;
         else if (below_hot_hyst) hot_alarm <= 1'b0;
         if (above_os) overtemp_alarm <= 1'b1;
         else if (below_os_hyst) overtemp_alarm <= 1'b0;
      end
   end

   // Comparator mode follows the overtemp setpoint alone
   logic os_cmp;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         os_cmp <= 1'b0;
      end else if (temp_updated) begin
         os_cmp <= above_os;
      end
   end
   assign overtemp_shutdown_output_n = temp_cfg[`FTR_OS_ONE_TIME_BIT] ?
      !overtemp_alarm : !os_cmp;

   // Reference tick at 22.5 kHz
   logic [15:0] ref_cnt;
   wire ref_tick = (ref_cnt == 16'(REF_DIV - 1));
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_cnt <= 16'h0;
      end else if (ref_tick) begin
         ref_cnt <= 16'h0;
      end else begin
         ref_cnt <= ref_cnt + 16'h1;
      end
   end

   // Fan period engine, shared by both inputs
   ftr_pkg::ftr_fan_div_t div_code;
   ftr_pkg::ftr_fan_state_t fan_state;
   ftr_pkg::ftr_fan_state_t next_fan_state;
   logic tach_prev;
   logic [2:0] pre_cnt;
   logic [1:0] edge_cnt;
   logic [7:0] fan_acc;
   wire tach = fan_sel ? second_tach_input : first_tach_input;
   wire level_mode = fan_sel ? fan_div_reg[`FTR_FAN_LEVEL_SECOND_BIT] :
      fan_div_reg[`FTR_FAN_LEVEL_FIRST_BIT];
   assign div_code = ftr_pkg::ftr_fan_div_t'(fan_sel ?
      fan_div_reg[`FTR_FAN_DIV_SECOND_LSB +: 2] :
      fan_div_reg[`FTR_FAN_DIV_FIRST_LSB +: 2]);
   wire [2:0] pre_top = (3'h1 << div_code) - 3'h1;
   wire tach_rise = tach && !tach_prev;
   wire count_tick = ref_tick && (pre_cnt == pre_top);
   wire gate_end = tach_rise && (edge_cnt == `FTR_TACH_GATE_EDGES - 2'h1);

   always_comb begin
      next_fan_state = fan_state;
      unique case (fan_state)
         ftr_pkg::FTR_F_IDLE: if (slot_begin && is_fan_slot && !level_mode) begin
            next_fan_state = ftr_pkg::FTR_F_ARM;
         end
         ftr_pkg::FTR_F_ARM: if (tach_rise) next_fan_state = ftr_pkg::FTR_F_COUNT;
         ftr_pkg::FTR_F_COUNT: if (gate_end) next_fan_state = ftr_pkg::FTR_F_DONE;
         ftr_pkg::FTR_F_DONE: next_fan_state = ftr_pkg::FTR_F_DONE;
      endcase
      if (slot_end) next_fan_state = ftr_pkg::FTR_F_IDLE;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fan_state <= ftr_pkg::FTR_F_IDLE;
         tach_prev <= 1'b0;
      end else begin
         fan_state <= next_fan_state;
         tach_prev <= tach;
      end
   end

   wire fan_counting = (fan_state == ftr_pkg::FTR_F_COUNT);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         edge_cnt <= 2'h0;
      end else if (!fan_counting) begin
         edge_cnt <= 2'h0;
      end else if (tach_rise) begin
         edge_cnt <= edge_cnt + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt <= 3'h0;
      end else if (!fan_counting) begin
         pre_cnt <= 3'h0;
      end else if (ref_tick) begin
         pre_cnt <= (pre_cnt == pre_top) ? 3'h0 : pre_cnt + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fan_acc <= 8'h00;
      end else if (!fan_counting) begin
         fan_acc <= 8'h00;
      end else if (count_tick && fan_acc != `FTR_FAN_MAX) begin
         fan_acc <= fan_acc + 8'h01;
      end
   end

   // Fan result: count at gate end, full scale on timeout, level in level mode
   wire fan_slot_live = is_fan_slot && loop_enable;
   wire fan_level_load = fan_slot_live && level_mode && slot_begin;
   wire fan_gate_load = fan_slot_live && fan_counting && gate_end;
   wire fan_timeout_load = fan_slot_live && slot_end && !level_mode &&
      (fan_state != ftr_pkg::FTR_F_DONE);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fan_count[0] <= 8'h00;
         fan_count[1] <= 8'h00;
      end else if (fan_level_load) begin
         fan_count[fan_sel] <= {7'h00, tach};
      end else if (fan_gate_load) begin
         fan_count[fan_sel] <= fan_acc;
      end else if (fan_timeout_load) begin
         fan_count[fan_sel] <= `FTR_FAN_MAX;
      end
   end

endmodule : ftr_readout
`default_nettype wire

/* ftr_readout_properties.sv */
// Port-level concurrent checks for the readout block
`default_nettype none
module ftr_readout_properties #(
   parameter int unsigned SLOT_CYCLES = 200,
   parameter int unsigned HIRES_EXTRA_CYCLES = 100
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic loop_enable,
   input wire ftr_pkg::ftr_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic conv_start,
   input wire logic [2:0] conv_sel,
   input wire logic conv_hires
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SLOT_D = SLOT_CYCLES;
   localparam int HI_D = SLOT_CYCLES + HIRES_EXTRA_CYCLES;
   logic [2:0] last_sel;
   logic seen;
   wire logic [2:0] next_sel = (last_sel == 3'h7) ? 3'h0 : last_sel + 3'h1;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_sel <= 3'h0;
         seen <= 1'b0;
      end else if (conv_start) begin
         last_sel <= conv_sel;
         seen <= 1'b1;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_volt_slot;
      conv_start && loop_enable && conv_sel inside {[3'h1:3'h6]};
   endsequence
   sequence s_hires_temp_slot;
      conv_start && loop_enable && conv_sel == 3'h0 && conv_hires;
   endsequence
   AST_UNMAPPED_READ: assert property (reg_req.rd && reg_req.addr >= 8'h2F |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_READ_HOLD: assert property (!reg_req.rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   AST_HIRES_CFG: assert property (reg_req.wr && reg_req.addr == 8'h06
      |=> conv_hires == $past(reg_req.wdata[3])) else $error("resolution bit not stored");
   AST_LOW_9BIT: assert property (reg_req.rd && reg_req.addr == 8'h06 && !conv_hires
      |=> reg_rdata[6:4] == 3'h0) else $error("meaningless low bits not zero");
   AST_START_PULSE: assert property (conv_start |=> !conv_start)
      else $error("conversion start longer than one cycle");
   AST_SLOT_ORDER: assert property (conv_start && seen |-> conv_sel == next_sel)
      else $error("slot order broken");
   AST_SLOT_SPACING: assert property (s_volt_slot |-> ##SLOT_D conv_start)
      else $error("voltage slot length wrong");
   AST_HIRES_SLOT: assert property (s_hires_temp_slot |-> ##HI_D (conv_start && conv_sel == 3'h1))
      else $error("high resolution temperature slot length wrong");
endmodule : ftr_readout_properties
bind ftr_readout ftr_readout_properties #(
   .SLOT_CYCLES(SLOT_CYCLES),
   .HIRES_EXTRA_CYCLES(HIRES_EXTRA_CYCLES)
) u_props (
   .clk(clk),
   .rst_n(rst_n),
   .loop_enable(loop_enable),
   .reg_req(reg_req),
   .reg_rdata(reg_rdata),
   .conv_start(conv_start),
   .conv_sel(conv_sel),
   .conv_hires(conv_hires)
);
`default_nettype wire

/* ftr_partner.sv */
// Converter and fan tachometer model at the far side of the readout block
`default_nettype none
module ftr_partner #(
   parameter int TACH_HALF = 24
) (
   input wire logic clk,
   input wire logic conv_start,
   input wire logic [2:0] conv_sel,
   input wire logic [11:0] temp_code,
   input wire logic [1:0] tach_run,
   input wire logic [1:0] tach_lvl,
   output ftr_pkg::ftr_conv_rsp_t conv_rsp,
   output logic first_tach_input,
   output logic second_tach_input
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sq = 1'b0;
   logic [2:0] sel;
   always begin
      repeat (TACH_HALF) @(posedge clk);
      #1 sq = ~sq;
   end
   assign first_tach_input = tach_run[0] ? sq : tach_lvl[0];
   assign second_tach_input = tach_run[1] ? sq : tach_lvl[1];
   initial conv_rsp = '0;
   // Answer each started conversion a few cycles into its slot
   always @(negedge clk) begin
      if (conv_start === 1'b1) begin
         sel = conv_sel;
         repeat (4) @(posedge clk);
         #1 conv_rsp = {1'b1, (sel == 3'h0) ? temp_code : {4'h0, 8'hBD + {5'h00, sel}}};
         @(posedge clk);
         #1 conv_rsp = '0;
      end
   end
endmodule : ftr_partner
`default_nettype wire

/* test_fan_tach_and_temp_readout.sv */
// Directed register-level test of the readout block
`default_nettype none
module test_fan_tach_and_temp_readout;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic loop_enable = 1'b0;
   ftr_pkg::ftr_reg_req_t reg_req = '0;
   ftr_pkg::ftr_conv_rsp_t conv_rsp;
   logic [7:0] reg_rdata;
   logic [2:0] conv_sel;
   logic conv_start, conv_hires, hot_alarm, overtemp_alarm, os_n, tach_a, tach_b;
   logic [11:0] temp_code = 12'h19E;
   logic [1:0] tach_run = 2'h3;
   logic [1:0] tach_lvl = 2'h0;
   logic [7:0] sp [4] = '{8'h18, 8'h14, 8'h18, 8'hE7};
   int fails = 0;
   int samples_checked = 0;
   always #5 clk = ~clk;
   ftr_readout #(.REF_DIV(4), .SLOT_CYCLES(200), .HIRES_EXTRA_CYCLES(100)) dut (
      .clk(clk), .rst_n(rst_n), .loop_enable(loop_enable), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .conv_start(conv_start), .conv_sel(conv_sel),
      .conv_hires(conv_hires), .conv_rsp(conv_rsp), .first_tach_input(tach_a),
      .second_tach_input(tach_b), .hot_alarm(hot_alarm), .overtemp_alarm(overtemp_alarm),
      .overtemp_shutdown_output_n(os_n));
   ftr_partner u_partner (.clk(clk), .conv_start(conv_start), .conv_sel(conv_sel),
      .temp_code(temp_code), .tach_run(tach_run), .tach_lvl(tach_lvl), .conv_rsp(conv_rsp),
      .first_tach_input(tach_a), .second_tach_input(tach_b));
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 reg_req = {1'b1, 1'b0, a, d};
      @(posedge clk);
      #1 reg_req = '0;
   endtask : reg_wr
   task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp, input bit near = 0);
      logic [7:0] d;
      @(posedge clk);
      #1 reg_req = {1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      #1 reg_req = '0;
      d = reg_rdata;
      if (near)
         check($sformatf("fan_%h", a), {7'h00, d >= exp - 8'h01 && d <= exp + 8'h01}, 8'h01);
      else
         check($sformatf("reg_%h", a), d, exp);
   endtask : reg_chk
   // Return once a full monitoring loop has run
   task automatic sync;
      int i;
      repeat (2) begin
         i = 0;
         @(negedge clk);
         while (!(conv_start === 1'b1 && conv_sel === 3'h0) && i < 4000) begin
            @(negedge clk);
            i++;
         end
         if (i >= 4000)
            fails++;
      end
      @(posedge clk);
      #1;
   endtask : sync
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   initial begin
      #1000000;
      fails++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      reg_chk(8'h05, 8'h14);
      reg_chk(8'h06, 8'h01);
      reg_chk(8'h3F, 8'h00);
      reg_wr(8'h28, 8'hFF);
      reg_chk(8'h28, 8'h00);
      loop_enable = 1'b1;
      for (int k = 0; k < 4; k++) begin
         reg_wr(8'h2B + k[7:0], sp[k]);
         reg_chk(8'h2B + k[7:0], sp[k]);
      end
      sync();
      reg_chk(8'h28, 8'h19);
      reg_chk(8'h06, 8'h81);
      for (int k = 0; k < 7; k++)
         reg_chk(8'h20 + k[7:0], 8'hBE + k[7:0]);
      reg_chk(8'h2A, 8'h0C, 1);
      check("hot_alarm", {7'h00, hot_alarm}, 8'h01);
      check("overtemp_alarm", {7'h00, overtemp_alarm}, 8'h01);
      check("os_n", {7'h00, os_n}, 8'h00);
      reg_wr(8'h06, 8'h05);
      reg_wr(8'h2D, 8'h1E);
      sync();
      check("os_one_time", {7'h00, os_n}, 8'h00);
      check("overtemp_held", {7'h00, overtemp_alarm}, 8'h01);
      reg_wr(8'h06, 8'h01);
      check("os_comparator", {7'h00, os_n}, 8'h01);
      for (int k = 0; k < 4; k++) begin
         reg_wr(8'h05, {4'h1, k[1:0], 2'h0});
         sync();
         reg_chk(8'h29, 8'h18 >> k, 1);
         reg_chk(8'h2A, 8'h0C, 1);
      end
      tach_run = 2'h2;
      sync();
      reg_chk(8'h29, 8'hFF);
      check("fan_fail", {7'h00, reg_rdata >= 8'hDB}, 8'h01);
      reg_wr(8'h05, 8'h15);
      tach_lvl = 2'h1;
      sync();
      reg_chk(8'h29, 8'h01);
      reg_wr(8'h06, 8'h09);
      sync();
      reg_chk(8'h06, 8'hE9);
      reg_chk(8'h28, 8'h19);
      temp_code = 12'hC90;
      sync();
      reg_chk(8'h28, 8'hC9);
      reg_chk(8'h06, 8'h09);
      check("hot_alarm", {7'h00, hot_alarm}, 8'h00);
      check("overtemp_alarm", {7'h00, overtemp_alarm}, 8'h00);
      check("os_n", {7'h00, os_n}, 8'h01);
      end_sim();
   end
endmodule : test_fan_tach_and_temp_readout
`default_nettype wire
